// ===== mjx_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "mjx_defines.svh"
module mjx_exec
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic [6:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             MEM_RD,
  output logic             MEM_WR,
  output logic      [15:0] MEM_ADDR,
  output logic      [15:0] MEM_WDATA,
  input  wire logic [15:0] MEM_RDATA,
  input  wire logic        MEM_ACK,
  output logic             IO_CMD_STB,
  output logic      [15:0] IO_CMD_WORD,
  output logic             REMOTE_STB,
  output logic      [15:0] REMOTE_WORD,
  output logic             RTC_RUN,
  output logic             STOPPED,
  input  wire logic        PWR_FAULT,
  input  wire logic        BOOT2_SEL,
  input  wire logic        STOP_KEY1,
  input  wire logic        STOP_KEY2
);
  import mjx_pkg::*;

  logic [15:0] regs_q [16];
  mjx_state_t  st_q;
  mjx_state_t  st_d;
  mjx_instr_t  ins_q;
  mjx_instr_t  nxt_ins;
  logic [15:0] y_q;
  logic [15:0] pc_q;
  logic [15:0] cc_q;
  logic [15:0] mdata_q;
  logic [15:0] tgt_q;
  logic [15:0] tx_q;
  logic [15:0] ty_q;
  logic [15:0] tz_q;
  logic [3:0]  it_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic        mem_rd_q;
  logic        mem_wr_q;
  logic [15:0] mem_addr_q;
  logic [15:0] mem_wdata_q;
  logic        io_stb_q;
  logic        rem_stb_q;
  logic [15:0] io_word_q;
  logic [15:0] rem_word_q;
  logic        rtc_q;
  logic        stopped_q;
  logic        jmp_take;
  logic        jmp_stop;
  logic [3:0]  ra_i;
  logic [3:0]  rm1_i;
  logic [3:0]  rz_i;
  logic [15:0] ra_v;
  logic [15:0] mask_v;
  logic [15:0] opnd;
  logic [15:0] msub_v;
  logic [15:0] am_v;
  logic [15:0] bm_v;
  logic [1:0]  cmp_code;
  logic [15:0] cx;
  logic [15:0] cy;
  logic [15:0] cz;
  logic        acc;
  logic        acc_wr;
  logic        start;
  logic        restart;
  logic        busy;
  logic        in_exec;
  logic        trig_last;

  // memory access needed before execution
  function automatic logic need_mem(mjx_op_t op, mjx_src_t src);
    case (op)
      OP_IOCMD, OP_BFETCH, OP_XREM: need_mem = 1'b1;
      OP_MSUB, OP_CMPM, OP_CJMP:    need_mem = (src == SRC_MEM);
      default:                      need_mem = 1'b0;
    endcase
  endfunction

  // instruction length in words
  function automatic logic [15:0] ilen(mjx_src_t src);
    ilen = (src == SRC_REG) ? 16'h0001 : 16'h0002;
  endfunction

  // condition code {negative, nonzero} of a word
  function automatic logic [1:0] cc_of(logic [15:0] w);
    cc_of = {w[15], |w};
  endfunction

  // arctangent of 2^-i, half turn = 16'h8000
  function automatic logic [15:0] atan_of(logic [3:0] i);
    case (i)
      4'h0:    atan_of = 16'h2000;
      4'h1:    atan_of = 16'h12e4;
      4'h2:    atan_of = 16'h09fb;
      4'h3:    atan_of = 16'h0511;
      4'h4:    atan_of = 16'h028b;
      4'h5:    atan_of = 16'h0146;
      4'h6:    atan_of = 16'h00a3;
      4'h7:    atan_of = 16'h0051;
      4'h8:    atan_of = 16'h0029;
      4'h9:    atan_of = 16'h0014;
      4'ha:    atan_of = 16'h000a;
      4'hb:    atan_of = 16'h0005;
      4'hc:    atan_of = 16'h0003;
      4'hd:    atan_of = 16'h0001;
      4'he:    atan_of = 16'h0001;
      default: atan_of = 16'h0000;
    endcase
  endfunction

  // bus handshake terms
  assign acc     = (AVS_READ | AVS_WRITE) & ~wait_q;
  assign acc_wr  = acc & AVS_WRITE;
  assign busy    = (st_q != S_IDLE) && (st_q != S_STOP);
  assign nxt_ins = mjx_instr_t'(AVS_WRITEDATA[13:0]);
  assign start   = acc_wr && (AVS_ADDRESS == `MJX_OFS_INSTR) &&
                   (st_q == S_IDLE);
  assign restart = acc_wr && (AVS_ADDRESS == `MJX_OFS_STATUS) &&
                   AVS_WRITEDATA[0] && (st_q == S_STOP);

  // operand selection
  assign ra_i      = ins_q.a;
  assign rm1_i     = ins_q.a + 4'h1;
  assign rz_i      = ins_q.a + 4'h2;
  assign ra_v      = regs_q[ra_i];
  assign mask_v    = regs_q[rm1_i];
  assign opnd      = (ins_q.src == SRC_REG) ? regs_q[ins_q.m] :
                     (ins_q.src == SRC_IMM) ? y_q : mdata_q;
  assign msub_v    = (ra_v & ~mask_v) | (opnd & mask_v);
  assign am_v      = ra_v & mask_v;
  assign bm_v      = opnd & mask_v;
  assign cmp_code  = mask_v[`MJX_MASK_EQMODE] ?
                     {1'b0, am_v != bm_v} :
                     {$signed(am_v) < $signed(bm_v), am_v != bm_v};
  assign in_exec   = (st_q == S_EXEC);
  assign trig_last = (st_q == S_TRIG) && (it_q == `MJX_CORDIC_LAST);

  mjx_jump_cond u_cond
  (
    .sel       (ins_q.a),
    .cc        (cc_q),
    .pwr_fault (PWR_FAULT),
    .boot2_sel (BOOT2_SEL),
    .stop_key1 (STOP_KEY1),
    .stop_key2 (STOP_KEY2),
    .take      (jmp_take),
    .stop      (jmp_stop)
  );

  // slave wait: one wait cycle, writes held off while busy
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      wait_q <= 1'b1;
    else if (acc)
      wait_q <= 1'b1;
    else if (AVS_READ || (AVS_WRITE && !busy))
      wait_q <= 1'b0;
  end

  // read decode, unmapped reads zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (AVS_ADDRESS[`MJX_WIN_BIT])
      rd_mux[15:0] = regs_q[AVS_ADDRESS[5:2]];
    else
      case (AVS_ADDRESS)
        `MJX_OFS_INSTR:  rd_mux[13:0] = ins_q;
        `MJX_OFS_OPY:    rd_mux[15:0] = y_q;
        `MJX_OFS_STATUS: rd_mux[2:0]  = {rtc_q, stopped_q, busy};
        `MJX_OFS_PC:     rd_mux[15:0] = pc_q;
        `MJX_OFS_CC:     rd_mux[15:0] = cc_q;
        default:         rd_mux = 32'h0000_0000;
      endcase
  end

  // read data captured as wait drops
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      rdata_q <= 32'h0000_0000;
    else if (AVS_READ && wait_q)
      rdata_q <= rd_mux;
  end

  // state register
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      st_q <= S_IDLE;
    else
      st_q <= st_d;
  end

  // sequencing
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      S_IDLE:
        if (start)
          st_d = (nxt_ins.op == OP_TRIG) ? S_TRIG :
                 need_mem(nxt_ins.op, nxt_ins.src) ? S_MRD : S_EXEC;
      S_MRD:  if (MEM_ACK) st_d = S_EXEC;
      S_EXEC:
        if (ins_q.op == OP_IOCMD || ins_q.op == OP_BFETCH)
          st_d = S_MWR;
        else if (ins_q.op == OP_CJMP && jmp_stop)
          st_d = S_HALT;
        else
          st_d = S_IDLE;
      S_MWR:  if (MEM_ACK) st_d = S_IDLE;
      S_TRIG: if (trig_last) st_d = S_IDLE;
      S_HALT: st_d = S_STOP;
      S_STOP: if (restart) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  // instruction and operand registers
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      ins_q <= mjx_instr_t'(14'h0000);
      y_q   <= 16'h0000;
    end
    else
    begin
      if (start)
        ins_q <= nxt_ins;
      if (acc_wr && AVS_ADDRESS == `MJX_OFS_OPY)
        y_q <= AVS_WRITEDATA[15:0];
    end
  end

  // main memory master
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      mdata_q     <= 16'h0000;
    end
    else
    begin
      if (start && need_mem(nxt_ins.op, nxt_ins.src))
      begin
        mem_rd_q   <= 1'b1;
        mem_addr_q <= (nxt_ins.op == OP_IOCMD) ?
                      `MJX_IOCMD_ADDR : y_q;
      end
      else if (mem_rd_q && MEM_ACK)
        mem_rd_q <= 1'b0;
      if (mem_rd_q && MEM_ACK)
        mdata_q <= MEM_RDATA;
      if (in_exec && ins_q.op == OP_IOCMD)
      begin
        mem_wr_q    <= 1'b1;
        mem_wdata_q <= mdata_q & `MJX_IOCLR_MASK;
      end
      else if (in_exec && ins_q.op == OP_BFETCH)
      begin
        mem_wr_q    <= 1'b1;
        mem_wdata_q <= mdata_q | `MJX_BIAS_MASK;
      end
      else if (mem_wr_q && MEM_ACK)
        mem_wr_q <= 1'b0;
    end
  end

  // i/o command and remote instruction strobes
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      io_stb_q   <= 1'b0;
      rem_stb_q  <= 1'b0;
      io_word_q  <= 16'h0000;
      rem_word_q <= 16'h0000;
    end
    else
    begin
      io_stb_q  <= in_exec && ins_q.op == OP_IOCMD;
      rem_stb_q <= in_exec && ins_q.op == OP_XREM;
      if (in_exec)
      begin
        io_word_q  <= mdata_q;
        rem_word_q <= mdata_q;
      end
    end
  end

  // real-time counter gate and stop flag
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      rtc_q     <= 1'b1;
      stopped_q <= 1'b0;
    end
    else if (restart)
    begin
      rtc_q     <= 1'b1;
      stopped_q <= 1'b0;
    end
    else
    begin
      if (in_exec && ins_q.op == OP_CJMP && jmp_stop)
        rtc_q <= 1'b0;
      if (st_q == S_HALT)
        stopped_q <= 1'b1;
    end
  end

  // instruction counter and stop target
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pc_q  <= `MJX_PC_RST;
      tgt_q <= `MJX_PC_RST;
    end
    else if (acc_wr && AVS_ADDRESS == `MJX_OFS_PC)
      pc_q <= AVS_WRITEDATA[15:0];
    else if (restart)
      pc_q <= tgt_q;
    else if (trig_last)
      pc_q <= pc_q + 16'h0001;
    else if (in_exec)
      case (ins_q.op)
        OP_CJMP:
          if (jmp_stop)
            tgt_q <= opnd;
          else if (jmp_take)
            pc_q <= opnd;
          else
            pc_q <= pc_q + ilen(ins_q.src);
        OP_LJMP: pc_q <= y_q;
        default: pc_q <= pc_q + ilen(ins_q.src);
      endcase
  end

  // condition code
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      cc_q <= `MJX_CC_RST;
    else if (acc_wr && AVS_ADDRESS == `MJX_OFS_CC)
      cc_q <= AVS_WRITEDATA[15:0];
    else if (in_exec)
      case (ins_q.op)
        OP_MSUB:   {cc_q[`MJX_CC_NEG], cc_q[`MJX_CC_NE]} <= cc_of(msub_v);
        OP_CMPM:   {cc_q[`MJX_CC_NEG], cc_q[`MJX_CC_NE]} <= cmp_code;
        OP_BFETCH: {cc_q[`MJX_CC_NEG], cc_q[`MJX_CC_NE]} <= cc_of(mdata_q);
        default:   cc_q <= cc_q;
      endcase
  end

  // rotation step, uncompensated gain
  always_comb
  begin
    logic dir;
    dir = ins_q.m[0] ? ty_q[15] : ~tz_q[15];
    cx  = dir ? tx_q - 16'($signed(ty_q) >>> it_q) :
                tx_q + 16'($signed(ty_q) >>> it_q);
    cy  = dir ? ty_q + 16'($signed(tx_q) >>> it_q) :
                ty_q - 16'($signed(tx_q) >>> it_q);
    cz  = dir ? tz_q - atan_of(it_q) : tz_q + atan_of(it_q);
  end

  // trig working registers
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      tx_q <= 16'h0000;
      ty_q <= 16'h0000;
      tz_q <= 16'h0000;
      it_q <= 4'h0;
    end
    else if (start)
    begin
      tx_q <= regs_q[nxt_ins.a];
      ty_q <= regs_q[nxt_ins.a + 4'h1];
      tz_q <= regs_q[nxt_ins.a + 4'h2];
      it_q <= 4'h0;
    end
    else if (st_q == S_TRIG)
    begin
      tx_q <= cx;
      ty_q <= cy;
      tz_q <= cz;
      it_q <= it_q + 4'h1;
    end
  end

  // register file
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < 16; i++)
        regs_q[i] <= `MJX_REG_RST;
    end
    else if (acc_wr && AVS_ADDRESS[`MJX_WIN_BIT])
      regs_q[AVS_ADDRESS[5:2]] <= AVS_WRITEDATA[15:0];
    else if (in_exec && ins_q.op == OP_MSUB)
      regs_q[ra_i] <= msub_v;
    else if (trig_last)
    begin
      regs_q[ra_i]  <= cx;
      regs_q[rm1_i] <= cy;
      regs_q[rz_i]  <= cz;
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign MEM_RD          = mem_rd_q;
  assign MEM_WR          = mem_wr_q;
  assign MEM_ADDR        = mem_addr_q;
  assign MEM_WDATA       = mem_wdata_q;
  assign IO_CMD_STB      = io_stb_q;
  assign IO_CMD_WORD     = io_word_q;
  assign REMOTE_STB      = rem_stb_q;
  assign REMOTE_WORD     = rem_word_q;
  assign RTC_RUN         = rtc_q;
  assign STOPPED         = stopped_q;

  // checks
  property p_msub;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_MSUB) |=>
      regs_q[$past(ra_i)] == (($past(ra_v) & ~$past(mask_v)) |
                              ($past(opnd) & $past(mask_v)));
  endproperty
  a_msub: assert property (p_msub)
    else $error("masked substitute result wrong");

  property p_msub_mem;
    @(posedge SYS_CLK) disable iff (RST)
    (mem_rd_q && MEM_ACK && ins_q.op == OP_MSUB) |=> ##1
      ((regs_q[ra_i] & mask_v) == ($past(MEM_RDATA, 2) & mask_v));
  endproperty
  a_msub_mem: assert property (p_msub_mem)
    else $error("memory masked substitute bits wrong");

  property p_cmpm;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_CMPM) |=>
      cc_q[`MJX_CC_NE] == ($past(am_v) != $past(bm_v));
  endproperty
  a_cmpm: assert property (p_cmpm)
    else $error("compare masked equality wrong");

  property p_cmpm_eq;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_CMPM && mask_v[`MJX_MASK_EQMODE]) |=>
      !cc_q[`MJX_CC_NEG];
  endproperty
  a_cmpm_eq: assert property (p_cmpm_eq)
    else $error("equal-only code has bit 9 set");

  property p_iocmd;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_IOCMD) |=> IO_CMD_STB && MEM_WR &&
      MEM_ADDR == `MJX_IOCMD_ADDR &&
      MEM_WDATA == ($past(mdata_q) & `MJX_IOCLR_MASK);
  endproperty
  a_iocmd: assert property (p_iocmd)
    else $error("i/o command write-back wrong");

  property p_bfetch;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_BFETCH) |=> MEM_WR &&
      MEM_WDATA == ($past(mdata_q) | `MJX_BIAS_MASK) &&
      cc_q[`MJX_CC_NEG] == $past(mdata_q[15]);
  endproperty
  a_bfetch: assert property (p_bfetch)
    else $error("biased fetch wrong");

  property p_xrem;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_XREM && ins_q.src == SRC_IMM) |=>
      REMOTE_STB && pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_xrem: assert property (p_xrem)
    else $error("execute remote resume wrong");

  property p_trig;
    @(posedge SYS_CLK) disable iff (RST)
    (start && nxt_ins.op == OP_TRIG) |-> ##17 (st_q == S_IDLE) &&
      regs_q[$past(ra_i)] == $past(cx);
  endproperty
  a_trig: assert property (p_trig)
    else $error("trig result not written back");

  property p_cjmp;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_CJMP && !jmp_stop) |=>
      pc_q == ($past(jmp_take) ? $past(opnd) :
               $past(pc_q) + ilen($past(ins_q.src)));
  endproperty
  a_cjmp: assert property (p_cjmp)
    else $error("conditional jump target wrong");

  property p_stop;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_CJMP && jmp_stop) |=>
      (!RTC_RUN && !STOPPED) ##1 (!RTC_RUN && STOPPED);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop sequence wrong");

  property p_ljmp;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.op == OP_LJMP) |=> pc_q == $past(y_q);
  endproperty
  a_ljmp: assert property (p_ljmp)
    else $error("local jump target wrong");

  property p_sel_cc;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.a[3:2] == 2'h0) |->
      jmp_take == (ins_q.a[1] ? cc_q[`MJX_CC_NEG] == ins_q.a[0] :
                                cc_q[`MJX_CC_NE] == ins_q.a[0]);
  endproperty
  a_sel_cc: assert property (p_sel_cc)
    else $error("code-bit selector wrong");

  property p_sel_hi;
    @(posedge SYS_CLK) disable iff (RST)
    (in_exec && ins_q.a[3:2] == 2'h3) |-> jmp_take && !jmp_stop;
  endproperty
  a_sel_hi: assert property (p_sel_hi)
    else $error("unassigned selector did not jump");

endmodule
`default_nettype wire

// ===== mjx_defines.svh
`ifndef MJX_DEFINES_SVH
`define MJX_DEFINES_SVH

// register byte offsets on the slave port
`define MJX_OFS_INSTR   7'h00
`define MJX_OFS_OPY     7'h04
`define MJX_OFS_STATUS  7'h08
`define MJX_OFS_PC      7'h0c
`define MJX_OFS_CC      7'h10
`define MJX_WIN_BIT     6

// reset values
`define MJX_PC_RST      16'h0000
`define MJX_CC_RST      16'h0000
`define MJX_REG_RST     16'h0000

// memory constants, octal 000140 for the i/o command word
`define MJX_IOCMD_ADDR  16'h0060
`define MJX_IOCLR_MASK  16'h3fff
`define MJX_BIAS_MASK   16'hc000

// condition code and mask bit positions
`define MJX_CC_NE       8
`define MJX_CC_NEG      9
`define MJX_CC_OVF      10
`define MJX_CC_CRY      11
`define MJX_MASK_EQMODE 15

// jump selector values, octal 0..13
`define MJX_SEL_EQ      4'h0
`define MJX_SEL_NE      4'h1
`define MJX_SEL_GE      4'h2
`define MJX_SEL_LT      4'h3
`define MJX_SEL_OVF     4'h4
`define MJX_SEL_CRY     4'h5
`define MJX_SEL_PWR     4'h6
`define MJX_SEL_BOOT2   4'h7
`define MJX_SEL_JMP     4'h8
`define MJX_SEL_STOP    4'h9
`define MJX_SEL_KEY1    4'ha
`define MJX_SEL_KEY2    4'hb

// rotation steps of the trig unit, last index
`define MJX_CORDIC_LAST 4'hf

`endif

// ===== mjx_pkg.sv
package mjx_pkg;

  typedef enum logic [3:0] {
    OP_MSUB   = 4'h0,
    OP_CMPM   = 4'h1,
    OP_IOCMD  = 4'h2,
    OP_BFETCH = 4'h3,
    OP_XREM   = 4'h4,
    OP_TRIG   = 4'h5,
    OP_CJMP   = 4'h6,
    OP_LJMP   = 4'h7
  } mjx_op_t;

  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_IMM = 2'h1,
    SRC_MEM = 2'h2
  } mjx_src_t;

  typedef struct packed {
    logic [3:0] m;
    logic [3:0] a;
    mjx_src_t   src;
    mjx_op_t    op;
  } mjx_instr_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_MRD  = 3'h1,
    S_EXEC = 3'h3,
    S_MWR  = 3'h2,
    S_TRIG = 3'h4,
    S_HALT = 3'h7,
    S_STOP = 3'h5
  } mjx_state_t;

endpackage

// ===== mjx_jump_cond.sv
`timescale 1ns/1ns
`default_nettype none
`include "mjx_defines.svh"
module mjx_jump_cond
(
  input  wire logic [3:0]  sel,
  input  wire logic [15:0] cc,
  input  wire logic        pwr_fault,
  input  wire logic        boot2_sel,
  input  wire logic        stop_key1,
  input  wire logic        stop_key2,
  output logic             take,
  output logic             stop
);

  // selector table, unassigned codes jump
  always_comb
  begin
    take = 1'b1;
    stop = 1'b0;
    case (sel)
      `MJX_SEL_EQ:    take = ~cc[`MJX_CC_NE];
      `MJX_SEL_NE:    take = cc[`MJX_CC_NE];
      `MJX_SEL_GE:    take = ~cc[`MJX_CC_NEG];
      `MJX_SEL_LT:    take = cc[`MJX_CC_NEG];
      `MJX_SEL_OVF:   take = cc[`MJX_CC_OVF];
      `MJX_SEL_CRY:   take = cc[`MJX_CC_CRY];
      `MJX_SEL_PWR:   take = pwr_fault;
      `MJX_SEL_BOOT2: take = boot2_sel;
      `MJX_SEL_JMP:   take = 1'b1;
      `MJX_SEL_STOP:
      begin
        take = 1'b0;
        stop = 1'b1;
      end
      `MJX_SEL_KEY1:
      begin
        take = ~stop_key1;
        stop = stop_key1;
      end
      `MJX_SEL_KEY2:
      begin
        take = ~stop_key2;
        stop = stop_key2;
      end
      default:        take = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// ===== mjx_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mjx_mem_model
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        SLOW,
  input  wire logic        MEM_RD,
  input  wire logic        MEM_WR,
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [15:0] MEM_WDATA,
  output logic      [15:0] MEM_RDATA,
  output logic             MEM_ACK
);
  logic [15:0] mem [0:255];
  logic [2:0]  cnt_q;
  // one ack pulse per request, prompt or four cycles late
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      MEM_ACK <= 1'b0;
      cnt_q <= 3'h0;
      MEM_RDATA <= 16'h0000;
    end
    else if ((MEM_RD || MEM_WR) && !MEM_ACK &&
             cnt_q >= (SLOW ? 3'h4 : 3'h0))
    begin
      MEM_ACK <= 1'b1;
      cnt_q <= 3'h0;
      if (MEM_WR)
      begin
        mem[MEM_ADDR[7:0]] <= MEM_WDATA;
        MEM_RDATA <= ~MEM_RDATA;
      end
      else
        MEM_RDATA <= mem[MEM_ADDR[7:0]];
    end
    else
    begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA; // word inverted every cycle between answers
      if ((MEM_RD || MEM_WR) && !MEM_ACK)
        cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ===== mjx_exec_test.sv
`timescale 1ns/1ns
`default_nettype none
module mjx_exec_test;
  import mjx_pkg::*;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, slow = 0;
  logic        pwr = 0, boot = 0, k1 = 0, k2 = 0, t, sp;
  logic [6:0]  adr = 7'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [15:0] q, p, c, mrdat, maddr, mwdat, iow, rw;
  logic        wq, mrd, mwr, mack, rtc, stp, ios, rms;
  int          errors = 0, total_checks = 0, io_n = 0, rm_n = 0;
  always #10 clk = ~clk;
  // strobe pulse counters
  always @(posedge clk) io_n <= io_n + ios;
  always @(posedge clk) rm_n <= rm_n + rms;
  mjx_exec dut_u (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .MEM_RD(mrd),
    .MEM_WR(mwr), .MEM_ADDR(maddr), .MEM_WDATA(mwdat),
    .MEM_RDATA(mrdat), .MEM_ACK(mack), .IO_CMD_STB(ios),
    .IO_CMD_WORD(iow), .REMOTE_STB(rms), .REMOTE_WORD(rw),
    .RTC_RUN(rtc), .STOPPED(stp), .PWR_FAULT(pwr),
    .BOOT2_SEL(boot), .STOP_KEY1(k1), .STOP_KEY2(k2));
  mjx_mem_model mem_u (.SYS_CLK(clk), .RST(rst), .SLOW(slow),
    .MEM_RD(mrd), .MEM_WR(mwr), .MEM_ADDR(maddr),
    .MEM_WDATA(mwdat), .MEM_RDATA(mrdat), .MEM_ACK(mack));
  // verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon access, held until waitrequest is low at a rising edge
  task automatic bus(input logic r, input logic [6:0] a,
                     input logic [15:0] d);
    int n;
    rd <= r;
    wr <= ~r;
    adr <= a;
    wd <= {16'h0000, d};
    n = 0;
    @(posedge clk);
    while (wq !== 1'b0 && n < 400)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 400)
    begin
      errors++;
      $display("[FAIL] %0t bus hang", $time);
      conclude();
    end
    q = rdat[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic getr(input logic [6:0] a, input logic [15:0] e);
    bus(1'b1, a, 16'h0000);
    chk(q, e);
  endtask
  // start an instruction and poll the busy flag
  task automatic run(input mjx_op_t o, input mjx_src_t s,
                     input logic [3:0] a, input logic [3:0] m);
    int n;
    bus(1'b0, 7'h00, {2'b00, m, a, s, o});
    n = 0;
    do
    begin
      bus(1'b1, 7'h08, 16'h0000);
      n++;
    end
    while (q[0] !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      errors++;
      $display("[FAIL] %0t busy hang", $time);
      conclude();
    end
  endtask
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 7'h48, 16'h1234);
    bus(1'b0, 7'h4c, 16'h0ff0);
    bus(1'b0, 7'h04, 16'habcd);
    run(OP_MSUB, SRC_IMM, 4'h2, 4'h0);
    getr(7'h48, 16'h1bc4);
    mem_u.mem[8'h20] = 16'h5555;
    bus(1'b0, 7'h04, 16'h0020);
    run(OP_MSUB, SRC_MEM, 4'h2, 4'h0);
    getr(7'h48, 16'h1554);
    $display("masked substitute done");
    bus(1'b0, 7'h4c, 16'h800f);
    for (int i = 0; i < 4; i++)
    begin
      c = (i == 0) ? 16'h7ff4 : (i == 1) ? 16'h0003 :
          (i == 2) ? 16'hff54 : 16'h0060;
      if (i == 2)
        bus(1'b0, 7'h4c, 16'h00ff);
      bus(1'b0, 7'h04, c);
      run(OP_CMPM, SRC_IMM, 4'h2, 4'h0);
      bus(1'b1, 7'h10, 16'h0000);
      chk(q & 16'h0300, (i == 1) ? 16'h0100 : (i == 3) ? 16'h0300 : 16'h0000);
    end
    $display("compare masked done");
    mem_u.mem[8'h60] = 16'hc00a;
    run(OP_IOCMD, SRC_REG, 4'h0, 4'h0);
    chk(iow, 16'hc00a);
    chk(16'(io_n), 16'h0001);
    chk(mem_u.mem[8'h60], 16'h000a);
    slow <= 1'b1;
    mem_u.mem[8'h30] = 16'h1234;
    bus(1'b0, 7'h04, 16'h0030);
    run(OP_BFETCH, SRC_MEM, 4'h0, 4'h0);
    chk(mem_u.mem[8'h30], 16'hd234);
    getr(7'h10, 16'h0100);
    slow <= 1'b0;
    bus(1'b1, 7'h0c, 16'h0000);
    p = q;
    mem_u.mem[8'h31] = 16'hbeef;
    bus(1'b0, 7'h04, 16'h0031);
    run(OP_XREM, SRC_IMM, 4'h0, 4'h0);
    chk(rw, 16'hbeef);
    chk(16'(rm_n), 16'h0001);
    getr(7'h0c, p + 16'h0002);
    bus(1'b0, 7'h60, 16'h1000);
    run(OP_TRIG, SRC_REG, 4'h6, 4'h0);
    getr(7'h58, 16'h0000);
    getr(7'h5c, 16'h0000);
    getr(7'h0c, p + 16'h0003);
    $display("memory ops done");
    bus(1'b0, 7'h54, 16'h0300);
    for (int i = 0; i < 32; i++)
    begin
      pwr <= i[4];
      boot <= i[4];
      k1 <= i[4];
      k2 <= i[4];
      bus(1'b0, 7'h04, 16'h0010);
      run(OP_LJMP, SRC_IMM, 4'h0, 4'h0);
      getr(7'h0c, 16'h0010);
      c = i[4] ? 16'h0f00 : 16'h0000;
      bus(1'b0, 7'h10, c);
      sp = (i[3:0] == 4'h9) || (i[3:0] == 4'ha && i[4]) ||
           (i[3:0] == 4'hb && i[4]);
      case (i[3:0])
        4'h0: t = !c[8];
        4'h1: t = c[8];
        4'h2: t = !c[9];
        4'h3: t = c[9];
        4'h4: t = c[10];
        4'h5: t = c[11];
        4'h6: t = i[4];
        4'h7: t = i[4];
        default: t = 1'b1;
      endcase
      run(OP_CJMP, SRC_REG, i[3:0], 4'h5);
      if (sp)
      begin
        for (int n = 0; n < 20 && stp !== 1'b1; n++)
          @(posedge clk);
        chk({15'h0000, stp}, 16'h0001);
        chk({15'h0000, rtc}, 16'h0000);
        bus(1'b0, 7'h08, 16'h0001);
        getr(7'h0c, 16'h0300);
        chk({14'h0000, rtc, stp}, 16'h0002);
      end
      else
        getr(7'h0c, t ? 16'h0300 : 16'h0011);
    end
    getr(7'h20, 16'h0000);
    $display("jump selectors done");
    conclude();
  end
endmodule
`default_nettype wire
